// [rtl/rst_pio_pkg.sv]
package rst_pio_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam real SYS_CLK_HZ   = 10.0e6;
	localparam real RST_MIN_MS   = 1.5;
	localparam real RST_MAX_MS   = 4.0;
	localparam real EXT_HOLD_MS  = 5.0;
	localparam real LF_OSC_HZ    = 32.0e3;
	localparam real BREAK_US     = 100.0;
	localparam int  RST_MIN_CYC  = int'($ceil(RST_MIN_MS * SYS_CLK_HZ / 1.0e3));
	localparam int  RST_MAX_CYC  = int'($floor(RST_MAX_MS * SYS_CLK_HZ / 1.0e3));
	localparam int  EXT_HOLD_CYC = int'($ceil(EXT_HOLD_MS * SYS_CLK_HZ / 1.0e3));
	localparam int  LF_DIV       = int'($floor(SYS_CLK_HZ / LF_OSC_HZ));
	localparam int  BREAK_CYC    = int'($ceil(BREAK_US * SYS_CLK_HZ / 1.0e6));
	localparam int  RST_HOLD_CYC = 16;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS      = 8'h00;
	localparam logic [7:0] WDOG_LOAD_OFS = 8'h04;
	localparam logic [7:0] WDOG_KICK_OFS = 8'h08;
	localparam logic [7:0] GP_CFG_OFS    = 8'h0c;
	localparam logic [7:0] GP_EVT_OFS    = 8'h10;
	localparam logic [7:0] STATUS_OFS    = 8'h14;
	localparam logic [7:0] CAUSE_OFS     = 8'h18;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_WDOG_EN = 0;
	localparam int CTRL_SLEEP   = 1;
	localparam int CTRL_AUX_LSB = 4;
	localparam int GP_DIR_LSB   = 0;
	localparam int GP_OUT_LSB   = 8;
	localparam int GP_PU_LSB    = 16;
	localparam int GP_STR_LSB   = 24;
	localparam int GP_IRQ_LSB   = 0;
	localparam int GP_WAKE_LSB  = 8;
	localparam int ST_FILT_BIT  = 8;
	localparam int ST_WCNT_LSB  = 16;
	localparam int CAUSE_PIN    = 0;
	localparam int CAUSE_POR    = 1;
	localparam int CAUSE_BRK    = 2;
	localparam int CAUSE_WDOG   = 3;
	localparam int GP_N         = 6;
	localparam int FX_N         = 4;

	// ------------------------------------------------------------
	// reset values and masks
	// ------------------------------------------------------------
	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK     = 32'h0000_0073;
	localparam logic [15:0] WDOG_LOAD_RST = 16'hffff;
	localparam logic [31:0] GP_CFG_RST    = 32'h0000_0000;
	localparam logic [31:0] GP_CFG_MASK   = 32'h3f3f_3f3f;
	localparam logic [31:0] GP_EVT_RST    = 32'h0000_0000;
	localparam logic [31:0] GP_EVT_MASK   = 32'h0000_3f3f;
	// fixed outputs: bit 0 serial tx, 1 rts, 2 audio data, 3 spi data
	localparam logic [3:0]  FX_PU_RST     = 4'h3;
	localparam logic [3:0]  FX_PD_RST     = 4'hc;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [2:0]
	{
		AUX_LOW, AUX_48M, AUX_24M, AUX_16M, AUX_8M, AUX_XTAL
	} aux_sel_e;

	typedef enum logic [1:0]
	{
		RS_ASSERT, RS_RELEASE, RS_RUN
	} rst_state_e;

endpackage

// [rtl/rst_filter.sv]
`timescale 1ns/10ps
module rst_filter
#(
	parameter int LF_DIV     = rst_pio_pkg::LF_DIV,
	parameter int FILT_TICKS = 50
)
(
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic pin_n,
	output logic      lf_tick_r,
	output logic      filt_low_r
);
	import rst_pio_pkg::*;

	logic [1:0]  sync_r;
	logic [15:0] div_r;
	logic [7:0]  tick_cnt_r;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			sync_r <= 2'h3;
		else
			sync_r <= {sync_r[0], pin_n};
	end

	// ------------------------------------------------------------
	// slow oscillator tick
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_r     <= 16'h0000;
			lf_tick_r <= 1'b0;
		end
		else if (div_r == 16'(LF_DIV - 1))
		begin
			div_r     <= 16'h0000;
			lf_tick_r <= 1'b1;
		end
		else
		begin
			div_r     <= div_r + 16'h0001;
			lf_tick_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// low-level filter, sampled only on slow ticks
	// ------------------------------------------------------------
	// glitches shorter than one tick are seen on one tick at most
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt_r <= 8'h00;
			filt_low_r <= 1'b0;
		end
		else if (lf_tick_r)
		begin
			if (sync_r[1])
			begin
				tick_cnt_r <= 8'h00;
				filt_low_r <= 1'b0;
			end
			else if (tick_cnt_r != 8'(FILT_TICKS))
			begin
				tick_cnt_r <= tick_cnt_r + 8'h01;
				filt_low_r <= (tick_cnt_r == 8'(FILT_TICKS - 1));
			end
		end
	end

endmodule

// [rtl/rst_pio_ctrl.sv]
`timescale 1ns/10ps
// Behaviour
// - reset is requested by the filtered pin, power-on, a serial break or watchdog expiry.
// - the active-low reset pin is filtered on slow oscillator ticks before it acts.
// - a held-low reset pin takes effect between 1.5 ms and 4.0 ms after it goes low.
// - in reset every two-way line is an input and every output is undriven.
// - at reset the six general lines are inputs with weak pull-downs.
// - each general line has software pull strength and pull direction.
// - each general line can raise an interrupt request or wake the block from sleep.
// - in reset serial tx and rts pull up, audio and spi data outputs pull down.
// - software selects one of the 48, 24, 16, 8 MHz or crystal clocks for the aux pin.
module rst_pio_ctrl
#(
	parameter int RST_MIN_CYC = rst_pio_pkg::RST_MIN_CYC,
	parameter int LF_DIV      = rst_pio_pkg::LF_DIV
)
(
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	input  wire logic                          ext_reset_n,
	input  wire logic                          por_n,
	input  wire logic                          uart_rx,
	input  wire logic [rst_pio_pkg::GP_N-1:0]  gp_line_in,
	output logic      [rst_pio_pkg::GP_N-1:0]  gp_line_out,
	output logic      [rst_pio_pkg::GP_N-1:0]  gp_line_oe,
	output logic      [rst_pio_pkg::GP_N-1:0]  gp_pull_up,
	output logic      [rst_pio_pkg::GP_N-1:0]  gp_pull_strong,
	output logic                               gp_irq_r,
	output logic                               wake_r,
	output logic                               sleep,
	input  wire logic [rst_pio_pkg::FX_N-1:0]  fixed_oe_in,
	output logic      [rst_pio_pkg::FX_N-1:0]  fixed_oe_r,
	output logic      [rst_pio_pkg::FX_N-1:0]  fixed_pu_r,
	output logic      [rst_pio_pkg::FX_N-1:0]  fixed_pd_r,
	output rst_pio_pkg::aux_sel_e              aux_sel,
	output logic                               core_rst_n_r,
	input  wire logic [7:0]                    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [7:0]                    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready
);
	import rst_pio_pkg::*;

	// slow ticks: first one may come at once after the fall, hence the extra one
	localparam int FILT_TICKS = (RST_MIN_CYC + LF_DIV - 1) / LF_DIV + 1;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb,
		input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r & mask;
	endfunction

	logic             lf_tick;
	logic             filt_low;
	logic [1:0]       por_sync_r;
	logic [1:0]       rx_sync_r;
	logic [GP_N-1:0]  gp_m_r;
	logic [GP_N-1:0]  gp_s_r;
	logic [GP_N-1:0]  gp_prev_r;
	logic [9:0]       brk_cnt_r;
	logic             brk_req;
	logic [15:0]      wdog_cnt_r;
	logic             wdog_req;
	logic             req;
	rst_state_e       rst_state_r;
	logic [4:0]       hold_cnt_r;
	logic             in_reset;
	logic [31:0]      ctrl_r;
	logic [15:0]      wdog_load_r;
	logic [31:0]      gp_cfg_r;
	logic [31:0]      gp_evt_r;
	logic [3:0]       cause_r;
	logic [7:0]       aw_addr_r;
	logic [31:0]      w_data_r;
	logic [3:0]       w_strb_r;
	logic             wr_go;
	logic             wr_hit;
	logic [31:0]      rdata_nxt;
	logic             rhit_nxt;

	rst_filter #(.LF_DIV(LF_DIV), .FILT_TICKS(FILT_TICKS)) u_filter
	(
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.pin_n      (ext_reset_n),
		.lf_tick_r  (lf_tick),
		.filt_low_r (filt_low)
	);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			por_sync_r <= 2'h0;
			rx_sync_r  <= 2'h3;
			gp_m_r     <= '0;
			gp_s_r     <= '0;
		end
		else
		begin
			por_sync_r <= {por_sync_r[0], por_n};
			rx_sync_r  <= {rx_sync_r[0], uart_rx};
			gp_m_r     <= gp_line_in;
			gp_s_r     <= gp_m_r;
		end
	end

	// ------------------------------------------------------------
	// reset sources
	// ------------------------------------------------------------
	// break fires once per low period so a parked line cannot loop resets
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			brk_cnt_r <= 10'h000;
		else if (rx_sync_r[1])
			brk_cnt_r <= 10'h000;
		else if (brk_cnt_r != 10'(BREAK_CYC))
			brk_cnt_r <= brk_cnt_r + 10'h001;
	end
	assign brk_req = (brk_cnt_r == 10'(BREAK_CYC - 1)) && !rx_sync_r[1];

	// watchdog counts slow ticks; enable is cleared by the reset it causes
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			wdog_cnt_r <= WDOG_LOAD_RST;
		else if (!ctrl_r[CTRL_WDOG_EN] || (wr_hit && aw_addr_r == WDOG_KICK_OFS))
			wdog_cnt_r <= wdog_load_r;
		else if (lf_tick && wdog_cnt_r != 16'h0000)
			wdog_cnt_r <= wdog_cnt_r - 16'h0001;
	end
	assign wdog_req = ctrl_r[CTRL_WDOG_EN] && (wdog_cnt_r == 16'h0000);

	assign req = filt_low || !por_sync_r[1] || brk_req || wdog_req;

	// ------------------------------------------------------------
	// core reset sequencer
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_state_r  <= RS_ASSERT;
			hold_cnt_r   <= 5'h00;
			core_rst_n_r <= 1'b0;
		end
		else
		begin
			unique case (rst_state_r)
				RS_ASSERT:
					if (!req)
					begin
						rst_state_r <= RS_RELEASE;
						hold_cnt_r  <= 5'h00;
					end
				RS_RELEASE:
					if (req)
						rst_state_r <= RS_ASSERT;
					else if (hold_cnt_r == 5'(RST_HOLD_CYC - 1))
					begin
						rst_state_r  <= RS_RUN;
						core_rst_n_r <= 1'b1;
					end
					else
						hold_cnt_r <= hold_cnt_r + 5'h01;
				RS_RUN:
					if (req)
					begin
						rst_state_r  <= RS_ASSERT;
						core_rst_n_r <= 1'b0;
					end
			endcase
		end
	end
	assign in_reset = !core_rst_n_r;

	// ------------------------------------------------------------
	// configuration registers, held at defaults during core reset
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_r <= CTRL_RST;
		else if (in_reset)
			ctrl_r <= CTRL_RST;
		else if (wake_r)
			ctrl_r[CTRL_SLEEP] <= 1'b0;
		else if (wr_hit && aw_addr_r == CTRL_OFS)
		begin
			ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r, CTRL_MASK);
			// unknown clock codes keep the previous selection
			if (w_strb_r[0] && w_data_r[CTRL_AUX_LSB +: 3] > 3'(AUX_XTAL))
				ctrl_r[CTRL_AUX_LSB +: 3] <= ctrl_r[CTRL_AUX_LSB +: 3];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			wdog_load_r <= WDOG_LOAD_RST;
		else if (in_reset)
			wdog_load_r <= WDOG_LOAD_RST;
		else if (wr_hit && aw_addr_r == WDOG_LOAD_OFS)
			wdog_load_r <= 16'(merge({16'h0000, wdog_load_r}, w_data_r,
				w_strb_r, 32'h0000_ffff));
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gp_cfg_r <= GP_CFG_RST;
			gp_evt_r <= GP_EVT_RST;
		end
		else if (in_reset)
		begin
			gp_cfg_r <= GP_CFG_RST;
			gp_evt_r <= GP_EVT_RST;
		end
		else if (wr_hit && aw_addr_r == GP_CFG_OFS)
			gp_cfg_r <= merge(gp_cfg_r, w_data_r, w_strb_r, GP_CFG_MASK);
		else if (wr_hit && aw_addr_r == GP_EVT_OFS)
			gp_evt_r <= merge(gp_evt_r, w_data_r, w_strb_r, GP_EVT_MASK);
	end

	assign gp_line_oe     = gp_cfg_r[GP_DIR_LSB +: GP_N];
	assign gp_line_out    = gp_cfg_r[GP_OUT_LSB +: GP_N];
	assign gp_pull_up     = gp_cfg_r[GP_PU_LSB +: GP_N];
	assign gp_pull_strong = gp_cfg_r[GP_STR_LSB +: GP_N];
	assign sleep          = ctrl_r[CTRL_SLEEP];
	assign aux_sel        = aux_sel_e'(ctrl_r[CTRL_AUX_LSB +: 3]);

	// sources are recorded even while the core sits in reset; set wins
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cause_r <= 4'h0;
		else
		begin
			for (int i = 0; i < 4; i++)
				if (wr_hit && aw_addr_r == CAUSE_OFS && w_strb_r[0] && w_data_r[i])
					cause_r[i] <= 1'b0;
			if (filt_low)
				cause_r[CAUSE_PIN] <= 1'b1;
			if (!por_sync_r[1])
				cause_r[CAUSE_POR] <= 1'b1;
			if (brk_req)
				cause_r[CAUSE_BRK] <= 1'b1;
			if (wdog_req)
				cause_r[CAUSE_WDOG] <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// general line events and fixed pins
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gp_prev_r <= '0;
			gp_irq_r  <= 1'b0;
			wake_r    <= 1'b0;
		end
		else
		begin
			gp_prev_r <= gp_s_r;
			gp_irq_r  <= |(gp_s_r & gp_evt_r[GP_IRQ_LSB +: GP_N]);
			wake_r    <= ctrl_r[CTRL_SLEEP] && !wake_r
				&& |((gp_s_r ^ gp_prev_r) & gp_evt_r[GP_WAKE_LSB +: GP_N]);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fixed_oe_r <= 4'h0;
			fixed_pu_r <= FX_PU_RST;
			fixed_pd_r <= FX_PD_RST;
		end
		else
		begin
			fixed_oe_r <= in_reset ? 4'h0 : fixed_oe_in;
			fixed_pu_r <= in_reset ? FX_PU_RST : 4'h0;
			fixed_pd_r <= in_reset ? FX_PD_RST : 4'h0;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_hit = wr_go && !in_reset;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_addr_r     <= 8'h00;
			w_data_r      <= 32'h0000_0000;
			w_strb_r      <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr_r     <= {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_data_r     <= s_axi_wdata;
				w_strb_r     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_r <= CAUSE_OFS) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		rhit_nxt  = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'b00})
			CTRL_OFS:      rdata_nxt = ctrl_r;
			WDOG_LOAD_OFS: rdata_nxt = {16'h0000, wdog_load_r};
			WDOG_KICK_OFS: rdata_nxt = 32'h0000_0000;
			GP_CFG_OFS:    rdata_nxt = gp_cfg_r;
			GP_EVT_OFS:    rdata_nxt = gp_evt_r;
			STATUS_OFS:    rdata_nxt = {wdog_cnt_r, 7'h00, filt_low, 2'h0, gp_s_r};
			CAUSE_OFS:     rdata_nxt = {28'h000_0000, cause_r};
			default:       rhit_nxt  = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rdata_nxt;
			s_axi_rresp   <= rhit_nxt ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

// [bench/rst_pio_chk_assertions.sv]
`timescale 1ns/10ps
module rst_pio_chk
#(
	parameter int RST_MIN_CYC = 20,
	parameter int LF_DIV      = 4
)
(
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       ext_reset_n,
	input wire logic       por_n,
	input wire logic       core_rst_n_r,
	input wire logic [3:0] fixed_oe_in,
	input wire logic [3:0] fixed_oe_r,
	input wire logic [3:0] fixed_pu_r,
	input wire logic [3:0] fixed_pd_r,
	input wire logic [5:0] gp_line_oe,
	input wire logic [5:0] gp_pull_up,
	input wire logic [5:0] gp_pull_strong,
	input wire logic       wake_r,
	input wire logic       sleep
);
	import rst_pio_pkg::*;
	// allow one slow tick beyond the scaled upper bound
	localparam int EARLY = RST_MIN_CYC + 1;
	localparam int LATE  = RST_MIN_CYC * 8 / 3 + LF_DIV;
	logic [15:0] low_cnt_r;

	// ----------
	// pin low time
	// ----------
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			low_cnt_r <= 16'h0000;
		else if (ext_reset_n)
			low_cnt_r <= 16'h0000;
		else if (low_cnt_r != 16'hffff)
			low_cnt_r <= low_cnt_r + 16'h0001;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	pin_early_a: assert property (
		$fell(core_rst_n_r) && low_cnt_r != 16'h0000 && por_n
		|-> low_cnt_r >= EARLY) else $error("pin reset too early");
	pin_late_a: assert property (low_cnt_r == LATE |-> !core_rst_n_r)
		else $error("pin reset too late");
	por_enter_a: assert property (!por_n [*4] |=> !core_rst_n_r)
		else $error("power-on reset missed");
	core_rel_a: assert property (
		$rose(core_rst_n_r) |-> $past(por_n, 8) && $past(ext_reset_n, 8))
		else $error("core reset left too soon");
	fixed_safe_a: assert property (
		!core_rst_n_r && !$past(core_rst_n_r) |-> fixed_oe_r == 4'h0
		&& fixed_pu_r == FX_PU_RST && fixed_pd_r == FX_PD_RST)
		else $error("fixed outputs not safe in reset");
	fixed_run_a: assert property (
		core_rst_n_r && $past(core_rst_n_r) |-> fixed_pu_r == 4'h0
		&& fixed_pd_r == 4'h0 && fixed_oe_r == $past(fixed_oe_in))
		else $error("fixed outputs wrong in run");
	gp_default_a: assert property (
		!core_rst_n_r && !$past(core_rst_n_r) |-> gp_line_oe == 6'h00
		&& gp_pull_up == 6'h00 && gp_pull_strong == 6'h00)
		else $error("general lines not weak inputs");
	wake_clear_a: assert property (wake_r |=> !wake_r ##1 !sleep)
		else $error("wake did not end sleep");
endmodule

bind rst_pio_ctrl rst_pio_chk #(.RST_MIN_CYC(RST_MIN_CYC), .LF_DIV(LF_DIV)) chk
(
	.sys_clk(sys_clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
	.por_n(por_n), .core_rst_n_r(core_rst_n_r),
	.fixed_oe_in(fixed_oe_in), .fixed_oe_r(fixed_oe_r),
	.fixed_pu_r(fixed_pu_r), .fixed_pd_r(fixed_pd_r),
	.gp_line_oe(gp_line_oe), .gp_pull_up(gp_pull_up),
	.gp_pull_strong(gp_pull_strong), .wake_r(wake_r), .sleep(sleep)
);

// [bench/board_src.sv]
`timescale 1ns/10ps
module board_src
(
	input  wire logic       sys_clk,
	input  wire logic [5:0] gp_line_out,
	input  wire logic [5:0] gp_line_oe,
	input  wire logic [5:0] gp_pull_up,
	output wire logic       ext_reset_n,
	output wire logic       por_n,
	output wire logic       uart_rx,
	output wire logic [5:0] gp_line_in
);
	int         low_cnt [3] = '{0, 0, 0};
	logic [5:0] host_en     = 6'h00;
	logic [5:0] host_val    = 6'h00;

	// ----------
	// reset sources: each line low while its count runs
	// ----------
	assign ext_reset_n = (low_cnt[0] == 0);
	assign por_n       = (low_cnt[1] == 0);
	assign uart_rx     = (low_cnt[2] == 0);
	always @(posedge sys_clk)
		for (int i = 0; i < 3; i++)
			if (low_cnt[i] > 0)
				low_cnt[i] <= low_cnt[i] - 1;
	// a released line settles to its pull, never to a stale value
	assign gp_line_in = (gp_line_oe & gp_line_out)
		| (~gp_line_oe & host_en & host_val)
		| (~gp_line_oe & ~host_en & gp_pull_up);
	task pulse(input int k, input int len);
		low_cnt[k] <= len;
	endtask
	task host(input logic [5:0] en, input logic [5:0] val);
		host_en  <= en;
		host_val <= val;
	endtask
endmodule

// [bench/module_reset_and_pio_defaults_bench.sv]
`timescale 1ns/10ps
module module_reset_and_pio_defaults_bench;
	import rst_pio_pkg::*;
	logic        sys_clk, rst_n, ext_reset_n, por_n, uart_rx;
	logic [5:0]  gp_line_in, gp_line_out, gp_line_oe, gp_pull_up;
	logic [5:0]  gp_pull_strong;
	logic        gp_irq_r, wake_r, sleep, core_rst_n_r;
	logic [3:0]  fixed_oe_in, fixed_oe_r, fixed_pu_r, fixed_pd_r, wstrb;
	aux_sel_e    aux_sel;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd_data;
	logic [1:0]  bresp, rresp, rd_resp, wr_resp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          error_cnt, compares;
	int          lens [3] = '{70, 10, 1100};
	logic [7:0]  ra [6] = '{CTRL_OFS, WDOG_LOAD_OFS, WDOG_KICK_OFS,
		GP_CFG_OFS, GP_EVT_OFS, 8'h1c};
	logic [31:0] pat [2] = '{32'h3f3f_3f3f, 32'h152a_0c33};

	rst_pio_ctrl #(.RST_MIN_CYC(20), .LF_DIV(4)) dut
	(
		.sys_clk(sys_clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
		.por_n(por_n), .uart_rx(uart_rx), .gp_line_in(gp_line_in),
		.gp_line_out(gp_line_out), .gp_line_oe(gp_line_oe),
		.gp_pull_up(gp_pull_up), .gp_pull_strong(gp_pull_strong),
		.gp_irq_r(gp_irq_r), .wake_r(wake_r), .sleep(sleep),
		.fixed_oe_in(fixed_oe_in), .fixed_oe_r(fixed_oe_r),
		.fixed_pu_r(fixed_pu_r), .fixed_pd_r(fixed_pd_r),
		.aux_sel(aux_sel), .core_rst_n_r(core_rst_n_r),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);
	board_src src
	(
		.sys_clk(sys_clk), .gp_line_out(gp_line_out),
		.gp_line_oe(gp_line_oe), .gp_pull_up(gp_pull_up),
		.ext_reset_n(ext_reset_n), .por_n(por_n), .uart_rx(uart_rx),
		.gp_line_in(gp_line_in)
	);

	// ----------
	// access tasks
	// ----------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// the trailing edge keeps a following call from re-driving in one step
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_on, w_on, b_on;
		aw_on = 1'b1;
		w_on = 1'b1;
		b_on = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (b_on)
		begin
			@(posedge sys_clk);
			wr_resp = bresp;
			b_on = !(bvalid === 1'b1 && !aw_on && !w_on);
			aw_on = aw_on && awready !== 1'b1;
			w_on = w_on && wready !== 1'b1;
			awvalid <= aw_on;
			wvalid <= w_on;
			bready <= b_on;
		end
		@(posedge sys_clk);
	endtask
	task automatic axi_rd(input logic [7:0] a);
		logic ar_on, r_on;
		ar_on = 1'b1;
		r_on = 1'b1;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (r_on)
		begin
			@(posedge sys_clk);
			if (!ar_on && rvalid === 1'b1)
			begin
				rd_data = rdata;
				rd_resp = rresp;
				r_on = 1'b0;
			end
			ar_on = ar_on && arready !== 1'b1;
			arvalid <= ar_on;
			rready <= r_on;
		end
		@(posedge sys_clk);
	endtask
	task automatic wait_core(input logic lvl);
		int t;
		t = 0;
		while (core_rst_n_r !== lvl && t < 3000)
		begin
			@(posedge sys_clk);
			t++;
		end
		if (t == 3000)
			chk(32'h0, 32'h1);
	endtask
	task summarize();
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------
	// stimulus
	// ----------
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial
	begin
		#1_000_000;
		error_cnt++;
		summarize();
	end
	initial
	begin
		{error_cnt, compares, rst_n, awvalid, wvalid, bready} = '0;
		{arvalid, rready, awaddr, araddr, wdata} = '0;
		fixed_oe_in = 4'ha;
		wstrb = 4'hf;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		wait_core(1'b1);
		@(posedge sys_clk);
		chk(32'(gp_line_oe | gp_pull_up | gp_pull_strong), 32'h0);
		chk(32'(fixed_oe_r), 32'ha);
		for (int i = 0; i < 6; i++)
		begin
			axi_rd(ra[i]);
			chk(rd_data, (i == 1) ? 32'h0000_ffff : 32'h0);
			chk(32'(rd_resp), (i == 5) ? RESP_SLVERR : RESP_OKAY);
		end
		axi_wr(8'h1c, 32'h0);
		chk(32'(wr_resp), 32'(RESP_SLVERR));
		for (int c = 0; c < 8; c++)
		begin
			axi_wr(CTRL_OFS, 32'(c) << CTRL_AUX_LSB);
			chk(32'(wr_resp), 32'(RESP_OKAY));
			chk(32'(aux_sel), (c > 5) ? 32'h5 : 32'(c));
		end
		for (int p = 0; p < 2; p++)
		begin
			axi_wr(GP_CFG_OFS, pat[p]);
			chk({gp_pull_strong, 2'b0, gp_pull_up, 2'b0, gp_line_out,
				2'b0, gp_line_oe}, pat[p]);
		end
		wstrb <= 4'h2;
		axi_wr(GP_CFG_OFS, 32'h0);
		chk({gp_pull_strong, 2'b0, gp_pull_up, 2'b0, gp_line_out,
			2'b0, gp_line_oe}, 32'h152a_0033);
		wstrb <= 4'hf;
		axi_wr(GP_CFG_OFS, 32'h0);
		axi_wr(GP_EVT_OFS, 32'h0000_0201);
		for (int v = 0; v < 2; v++)
		begin
			src.host(6'h3f, 6'h20 | 6'(v));
			repeat (5) @(posedge sys_clk);
			chk(32'(gp_irq_r), 32'(v));
			axi_rd(STATUS_OFS);
			chk(rd_data & 32'h0000_013f, 32'h20 | 32'(v));
		end
		axi_wr(CTRL_OFS, 32'h2);
		chk(32'(sleep), 32'h1);
		src.host(6'h3f, 6'h23);
		repeat (4) @(posedge sys_clk);
		chk(32'(wake_r), 32'h1);
		repeat (2) @(posedge sys_clk);
		chk(32'(sleep), 32'h0);
		src.host(6'h00, 6'h00);
		for (int k = 0; k < 4; k++)
		begin
			axi_wr(GP_CFG_OFS, 32'h3f3f_3f3f);
			axi_wr(CAUSE_OFS, 32'hf);
			if (k == 3)
			begin
				axi_wr(WDOG_LOAD_OFS, 32'h3);
				axi_wr(CTRL_OFS, 32'h1);
				axi_wr(WDOG_KICK_OFS, 32'h0);
			end
			else
				src.pulse(k, lens[k]);
			wait_core(1'b0);
			repeat (2) @(posedge sys_clk);
			chk({fixed_oe_r, fixed_pu_r, fixed_pd_r}, 12'h03c);
			chk(32'(gp_line_oe | gp_pull_up), 32'h0);
			axi_wr(GP_CFG_OFS, 32'h3f);
			wait_core(1'b1);
			axi_rd(GP_CFG_OFS);
			chk(rd_data, GP_CFG_RST);
			axi_rd(CAUSE_OFS);
			chk(rd_data, 32'h1 << k);
		end
		summarize();
	end
endmodule
